// file: pbba_consts.svh
// Purpose: constants of the bridge bus arbitration block
// Assumes: included by the package only
// Notes:   offsets are AXI4-Lite byte addresses
`ifndef PBBA_CONSTS_SVH
`define PBBA_CONSTS_SVH

// ----------------------------------------------------------------
// masters and widths
// ----------------------------------------------------------------
`define PBBA_NM          5
`define PBBA_NEXT        4
`define PBBA_IDX_W       3
`define PBBA_BRIDGE      3'h4
`define PBBA_SYNC_W      9
`define PBBA_ADDR_W      12

// ----------------------------------------------------------------
// timing counts in aclk cycles
// ----------------------------------------------------------------
`define PBBA_IDLE_LIMIT  5'h10
`define PBBA_TERM_HOLD   2'h2
`define PBBA_TTP_W       7

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PBBA_OFF_PARK    12'h048
`define PBBA_OFF_PREEMPT 12'h04c
`define PBBA_OFF_STATUS  12'h050
`define PBBA_BIT_ARB_DIS 0
`define PBBA_BIT_PARK_BR 1
`define PBBA_BIT_PRE_OFF 31
`define PBBA_TTP_HI      30
`define PBBA_TTP_LO      28
`define PBBA_HIPRI_HI    4
`define PBBA_HIPRI_LO    0
`define PBBA_RESP_OKAY   2'h0
`define PBBA_RESP_SLVERR 2'h2

`endif

// file: pbba_pkg.sv
// Purpose: types of the bridge bus arbitration block
// Assumes: pbba_consts.svh next to this file
// Notes:   one packed state struct, for the top module only
package pbba_pkg;
`include "pbba_consts.svh"

    // ------------------------------------------------------------
    // secondary arbiter states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ARB_OWN, ARB_GAP, ARB_OFF} pbba_arb_t;

    // ------------------------------------------------------------
    // state of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`PBBA_SYNC_W-1:0] sync1;
        logic [`PBBA_SYNC_W-1:0] sync2;
        logic [1:0]              hold;
        logic                    req_n;
        logic                    start;
        logic                    in_xfer;
        logic                    adcbe_oe;
        logic                    par_oe;
        pbba_arb_t               arb;
        logic [`PBBA_IDX_W-1:0]  owner;
        logic [`PBBA_NEXT-1:0]   sec_gnt_n;
        logic                    bridge_gnt;
        logic                    gnt_oe;
        logic [4:0]              idle_cnt;
        logic [`PBBA_TTP_W-1:0]  wait_cnt;
        logic                    arb_dis;
        logic                    park_br;
        logic                    pre_off;
        logic [2:0]              ttp;
        logic [`PBBA_NM-1:0]     hipri;
        logic                    aw_got;
        logic                    w_got;
        logic [`PBBA_ADDR_W-1:0] awaddr;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } pbba_state_t;

endpackage : pbba_pkg

// file: pbba_rr_pick.sv
// Purpose: rotating pick of one requester after the last owner
// Assumes: purely combinational
// Notes:   used once per priority level
`timescale 1ns/10ps
module pbba_rr_pick
    import pbba_pkg::*;
#(
    parameter int N  = `PBBA_NM,
    parameter int IW = `PBBA_IDX_W
)
(
    input  wire logic [N-1:0]  req,
    input  wire logic [IW-1:0] last,
    output logic               valid,
    output logic [IW-1:0]      idx
);

    // ------------------------------------------------------------
    // search downward so the nearest one after last wins
    // ------------------------------------------------------------
    always_comb
    begin
        valid = 1'b0;
        idx   = last;
        for (int k = N; k >= 1; k--)
        begin
            if (req[(int'(last) + k) % N])
            begin
                valid = 1'b1;
                idx   = IW'((int'(last) + k) % N);
            end
        end
    end

endmodule : pbba_rr_pick

// file: pbba_top.sv
// Purpose: primary request/park and secondary arbiter of a bridge
// Assumes: one clock aclk; pins pass two flip-flops first
// Notes:   registers over AXI4-Lite; clk_en low freezes all state
`timescale 1ns/10ps

module pbba_top
    import pbba_pkg::*;
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    clk_en,
    input  wire logic [`PBBA_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`PBBA_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    up_pending,
    input  wire logic                    up_term,
    input  wire logic                    up_done,
    input  wire logic                    pri_gnt_n,
    input  wire logic                    pri_frame_n,
    input  wire logic                    pri_irdy_n,
    output logic                         pri_req_n,
    output logic                         pri_start,
    output logic                         pri_ad_cbe_oe,
    output logic                         upstream_parity_oe,
    input  wire logic                    sec_bridge_req,
    input  wire logic [`PBBA_NEXT-1:0]   sec_req_n,
    input  wire logic                    sec_frame_n,
    input  wire logic                    downstream_initiator_ready_n,
    output logic [`PBBA_NEXT-1:0]        sec_gnt_n,
    output logic                         sec_gnt_oe,
    output logic                         sec_bridge_gnt
);

    localparam pbba_state_t ST_RST = '{
        sync1: '1, sync2: '1, req_n: 1'b1, arb: ARB_OWN,
        owner: `PBBA_BRIDGE, sec_gnt_n: '1, bridge_gnt: 1'b1,
        gnt_oe: 1'b1, default: '0};

    pbba_state_t             s_q;
    pbba_state_t             s_d;
    logic                    gnt_s;
    logic                    pri_idle;
    logic                    sec_busy;
    logic [`PBBA_NM-1:0]     req5;
    logic [`PBBA_NM-1:0]     own_oh;
    logic [`PBBA_NM-1:0]     others;
    logic                    own_req;
    logic                    hi_v;
    logic                    lo_v;
    logic [`PBBA_IDX_W-1:0]  hi_idx;
    logic [`PBBA_IDX_W-1:0]  lo_idx;
    logic                    pick_v;
    logic [`PBBA_IDX_W-1:0]  pick;
    logic [`PBBA_TTP_W-1:0]  ttp_cyc;
    logic                    preempt;
    logic                    timeout;
    logic                    gnt_on;
    logic [`PBBA_NM-1:0]     gvec;
    logic [31:0]             wmask;
    logic [31:0]             word;

    // ------------------------------------------------------------
    // synchronised pins, only stage two is read
    // ------------------------------------------------------------
    assign gnt_s    = !s_q.sync2[0];
    assign pri_idle = s_q.sync2[1] && s_q.sync2[2];
    assign sec_busy = !s_q.sync2[7] || !s_q.sync2[8];
    assign req5     = {sec_bridge_req, ~s_q.sync2[6:3]};
    assign own_oh   = `PBBA_NM'(1) << s_q.owner;
    assign others   = req5 & ~own_oh;
    assign own_req  = |(req5 & own_oh);
    assign gnt_on   = s_q.bridge_gnt || !(&s_q.sec_gnt_n);

    // ------------------------------------------------------------
    // two-level rotating pick
    // ------------------------------------------------------------
    pbba_rr_pick #(.N(`PBBA_NM), .IW(`PBBA_IDX_W)) u_pick_hi (
        .req   (others & s_q.hipri),
        .last  (s_q.owner),
        .valid (hi_v),
        .idx   (hi_idx)
    );

    pbba_rr_pick #(.N(`PBBA_NM), .IW(`PBBA_IDX_W)) u_pick_lo (
        .req   (others & ~s_q.hipri),
        .last  (s_q.owner),
        .valid (lo_v),
        .idx   (lo_idx)
    );

    assign pick_v = hi_v || lo_v;
    assign pick   = hi_v ? hi_idx : lo_idx;

    // code 0 gives no wait, others a power of two
    assign ttp_cyc = (s_q.ttp == 3'h0) ? '0 :
                     `PBBA_TTP_W'(1) << (s_q.ttp - 3'h1);
    assign preempt = !s_q.pre_off && pick_v && gnt_on &&
                     (s_q.wait_cnt >= ttp_cyc);
    assign timeout = s_q.owner != `PBBA_BRIDGE && gnt_on && !sec_busy &&
                     s_q.idle_cnt == `PBBA_IDLE_LIMIT - 5'h1;

    // ------------------------------------------------------------
    // register word views
    // ------------------------------------------------------------
    function automatic logic [31:0] reg_word(
        input pbba_state_t             st,
        input logic [`PBBA_ADDR_W-1:0] a
    );
        logic [31:0] w;
        w = '0;
        if (a == `PBBA_OFF_PARK)
        begin
            w[`PBBA_BIT_ARB_DIS] = st.arb_dis;
            w[`PBBA_BIT_PARK_BR] = st.park_br;
        end
        else if (a == `PBBA_OFF_PREEMPT)
        begin
            w[`PBBA_BIT_PRE_OFF]               = st.pre_off;
            w[`PBBA_TTP_HI:`PBBA_TTP_LO]       = st.ttp;
            w[`PBBA_HIPRI_HI:`PBBA_HIPRI_LO]   = st.hipri;
        end
        else if (a == `PBBA_OFF_STATUS)
        begin
            w[15:0] = {3'h0, st.in_xfer, !st.req_n, st.arb,
                       st.bridge_gnt, ~st.sec_gnt_n, 1'b0, st.owner};
        end
        return w;
    endfunction : reg_word

    function automatic logic mapped(input logic [`PBBA_ADDR_W-1:0] a);
        return a == `PBBA_OFF_PARK || a == `PBBA_OFF_PREEMPT ||
               a == `PBBA_OFF_STATUS;
    endfunction : mapped

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d   = s_q;
        wmask = '0;
        word  = '0;
        gvec  = '0;

        s_d.sync1 = {downstream_initiator_ready_n, sec_frame_n, sec_req_n,
                     pri_irdy_n, pri_frame_n, pri_gnt_n};
        s_d.sync2 = s_q.sync1;

        // primary request and start
        if (up_term)
            s_d.hold = `PBBA_TERM_HOLD;
        else if (s_q.hold != 2'h0)
            s_d.hold = s_q.hold - 2'h1;
        // pending counts only fully stored transactions
        s_d.req_n = !(up_pending && s_d.hold == 2'h0);
        s_d.start = !s_q.in_xfer && !s_q.req_n && gnt_s &&
                    pri_idle && !up_term;
        if (s_d.start)
            s_d.in_xfer = 1'b1;
        else if (up_done || up_term)
            s_d.in_xfer = 1'b0;
        s_d.adcbe_oe = gnt_s && s_q.req_n && pri_idle &&
                       !s_q.in_xfer;
        s_d.par_oe   = s_d.adcbe_oe && s_q.adcbe_oe;

        // secondary arbiter
        if (preempt || !pick_v || !gnt_on)
            s_d.wait_cnt = '0;
        else if (s_q.wait_cnt != '1)
            s_d.wait_cnt = s_q.wait_cnt + `PBBA_TTP_W'(1);
        if (gnt_on && !sec_busy && s_q.owner != `PBBA_BRIDGE)
            s_d.idle_cnt = s_q.idle_cnt + 5'h1;
        else
            s_d.idle_cnt = '0;

        case (s_q.arb)
            ARB_OWN:
            begin
                gvec = own_oh;
                if (s_q.arb_dis)
                begin
                    gvec      = '0;
                    s_d.arb   = ARB_OFF;
                end
                else if (timeout || (pick_v && (!own_req || preempt)) ||
                         (s_q.park_br && !pick_v && !own_req &&
                          s_q.owner != `PBBA_BRIDGE))
                begin
                    s_d.owner    = pick_v ? pick : `PBBA_BRIDGE;
                    s_d.idle_cnt = '0;
                    s_d.wait_cnt = '0;
                    if (sec_busy)
                        gvec = `PBBA_NM'(1) << s_d.owner;
                    else
                    begin
                        gvec    = '0;
                        s_d.arb = ARB_GAP;
                    end
                end
            end
            ARB_GAP:
            begin
                gvec    = own_oh;
                s_d.arb = ARB_OWN;
            end
            ARB_OFF:
            begin
                // handing back waits one idle clock
                if (!s_q.arb_dis)
                begin
                    s_d.owner = `PBBA_BRIDGE;
                    s_d.arb   = ARB_GAP;
                end
            end
            default:
            begin
                s_d.arb = ARB_GAP;
            end
        endcase
        s_d.sec_gnt_n  = ~gvec[`PBBA_NEXT-1:0];
        s_d.bridge_gnt = gvec[`PBBA_NEXT];
        s_d.gnt_oe     = s_d.arb != ARB_OFF;

        // AXI4-Lite write, address and data in either order
        if (s_axi_awvalid && s_q.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = {s_axi_awaddr[`PBBA_ADDR_W-1:2], 2'h0};
        end
        if (s_axi_wvalid && s_q.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got)
        begin
            for (int b = 0; b < 4; b++)
                wmask[b*8 +: 8] = {8{s_q.wstrb[b]}};
            word = (reg_word(s_q, s_q.awaddr) & ~wmask) |
                   (s_q.wdata & wmask);
            if (s_q.awaddr == `PBBA_OFF_PARK)
            begin
                s_d.arb_dis = word[`PBBA_BIT_ARB_DIS];
                s_d.park_br = word[`PBBA_BIT_PARK_BR];
            end
            if (s_q.awaddr == `PBBA_OFF_PREEMPT)
            begin
                s_d.pre_off = word[`PBBA_BIT_PRE_OFF];
                s_d.ttp     = word[`PBBA_TTP_HI:`PBBA_TTP_LO];
                s_d.hipri   = word[`PBBA_HIPRI_HI:`PBBA_HIPRI_LO];
            end
            s_d.bresp  = mapped(s_q.awaddr) ? `PBBA_RESP_OKAY :
                                              `PBBA_RESP_SLVERR;
            s_d.bvalid = 1'b1;
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
        end
        else if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;
        s_d.awready = !s_d.aw_got && !s_d.bvalid && !s_q.bvalid;
        s_d.wready  = !s_d.w_got && !s_d.bvalid && !s_q.bvalid;

        // AXI4-Lite read
        if (s_axi_arvalid && s_q.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = reg_word(s_q, s_axi_araddr & ~`PBBA_ADDR_W'(3));
            s_d.rresp  = mapped(s_axi_araddr & ~`PBBA_ADDR_W'(3)) ?
                         `PBBA_RESP_OKAY : `PBBA_RESP_SLVERR;
        end
        else if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;
        s_d.arready = !s_d.rvalid && !s_q.rvalid;
    end

    // ------------------------------------------------------------
    // state register, frozen while clk_en is low
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= ST_RST;
        else if (clk_en)
            s_q <= s_d;
    end

    assign s_axi_awready      = s_q.awready;
    assign s_axi_wready       = s_q.wready;
    assign s_axi_bresp        = s_q.bresp;
    assign s_axi_bvalid       = s_q.bvalid;
    assign s_axi_arready      = s_q.arready;
    assign s_axi_rdata        = s_q.rdata;
    assign s_axi_rresp        = s_q.rresp;
    assign s_axi_rvalid       = s_q.rvalid;
    assign pri_req_n          = s_q.req_n;
    assign pri_start          = s_q.start;
    assign pri_ad_cbe_oe      = s_q.adcbe_oe;
    assign upstream_parity_oe = s_q.par_oe;
    assign sec_gnt_n          = s_q.sec_gnt_n;
    assign sec_gnt_oe         = s_q.gnt_oe;
    assign sec_bridge_gnt     = s_q.bridge_gnt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clk_en);

    a_term_drop: assert property (up_term |=> pri_req_n [*2])
        else $error("request not dropped two clocks after termination");
    a_req_held: assert property (
        up_pending && !up_term && s_q.hold == 2'h0 |=> !pri_req_n)
        else $error("request not held with upstream work queued");
    a_start_gnt: assert property (
        pri_start |-> $past(!pri_req_n && gnt_s))
        else $error("start without prior request and grant");
    a_float_gnt: assert property (!gnt_s |=> !pri_ad_cbe_oe)
        else $error("primary lines driven after grant removed");
    a_par_later: assert property (
        $rose(upstream_parity_oe) |-> $past(pri_ad_cbe_oe) && pri_ad_cbe_oe)
        else $error("parity driven before address and command");
    a_one_gnt: assert property (
        $onehot0({sec_bridge_gnt, ~sec_gnt_n}))
        else $error("more than one secondary grant");
    a_idle_gap: assert property (
        $past({sec_bridge_gnt, ~sec_gnt_n}) != '0 &&
        {sec_bridge_gnt, ~sec_gnt_n} != '0 &&
        {sec_bridge_gnt, ~sec_gnt_n} != $past({sec_bridge_gnt, ~sec_gnt_n})
        |-> $past(sec_busy))
        else $error("grant moved on idle bus without gap");
    a_idle_limit: assert property (
        timeout && s_q.arb == ARB_OWN && !s_q.arb_dis
        |=> s_q.owner != $past(s_q.owner) || !gnt_on)
        else $error("idle grant not withdrawn after limit");

endmodule : pbba_top

// file: pbba_partner.sv
// Purpose: outside primary arbiter and secondary masters
// Assumes: drives no frames; the bench alone drives sec_frame_n low
// Notes:   grant follows request one clock late
`timescale 1ns/10ps
module pbba_partner
(
    input  wire logic       aclk,
    input  wire logic       pri_req_n,
    input  wire logic       park,
    input  wire logic [3:0] want,
    output logic            pri_gnt_n,
    output logic [3:0]      sec_req_n
);
    // ----------------------------------------------------------
    // grant on request, or parked at the bridge
    // ----------------------------------------------------------
    initial pri_gnt_n = '1;
    initial sec_req_n = '1;
    always @(posedge aclk)
    begin
        pri_gnt_n <= pri_req_n & ~park;
        sec_req_n <= ~want;
    end
endmodule : pbba_partner

// file: test_pci_bridge_bus_arbitration.sv
// Purpose: self-checking bench of the bridge arbitration block
// Assumes: partner idles both buses
// Notes:   preemption only at time-to-preempt 0, bench holds frame busy
`timescale 1ns/10ps
module test_pci_bridge_bus_arbitration;
    logic        aclk = '0, aresetn = '0, clk_en = '1, park = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic        s_axi_arvalid = '0, s_axi_rready = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, sec_req_n, sec_gnt_n, want = '0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, pri_gnt_n, sec_gnt_oe;
    logic        up_pending = '0, up_term = '0, up_done = '0;
    logic        pri_frame_n = '1, pri_irdy_n = '1, sec_frame_n = '1;
    logic        downstream_initiator_ready_n = '1, sec_bridge_req = '0;
    logic        pri_req_n, pri_start, pri_ad_cbe_oe, upstream_parity_oe;
    logic        sec_bridge_gnt;
    int          errors = 0, samples_checked = 0, n;

    pbba_top i_dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .up_pending, .up_term,
        .up_done, .pri_gnt_n, .pri_frame_n, .pri_irdy_n, .pri_req_n,
        .pri_start, .pri_ad_cbe_oe, .upstream_parity_oe, .sec_bridge_req,
        .sec_req_n, .sec_frame_n, .downstream_initiator_ready_n,
        .sec_gnt_n, .sec_gnt_oe, .sec_bridge_gnt);
    pbba_partner i_far (.aclk, .pri_req_n, .park, .want, .pri_gnt_n,
        .sec_req_n);

    initial forever #20 aclk = ~aclk;

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task step;
        @(posedge aclk);
        n++;
    endtask : step
    task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        // one edge between calls, so bready is never set twice at once
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= '1;
        s_axi_wvalid  <= '1;
        s_axi_bready  <= '1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= '0;
            if (s_axi_wready)
                s_axi_wvalid <= '0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= '0;
        chk(s_axi_bresp, e);
    endtask : axw
    task axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= '1;
        s_axi_rready  <= '1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= '0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= '0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, e);
    endtask : axr
    task results;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task t_regs;
        axr(12'h048, 32'h0, 2'h0);
        axr(12'h04c, 32'h0, 2'h0);
        axr(12'h0f0, 32'h0, 2'h2);
        axw(12'h0f4, 32'h1, 2'h2);
        axw(12'h04c, 32'hf0000000, 2'h0);
        axr(12'h04c, 32'hf0000000, 2'h0);
        axw(12'h04c, 32'h0, 2'h0);
    endtask : t_regs
    task t_pri;
        up_pending <= '1;
        n = 0;
        while (pri_start !== 1'h1 && n < 20) step;
        chk(pri_req_n, 1'h0);
        chk(n < 20, 1'h1);
        up_term <= '1;
        @(posedge aclk);
        up_term <= '0;
        // work still queued, so only the hold keeps the request off
        repeat (2)
        begin
            @(posedge aclk);
            chk(pri_req_n, 1'h1);
        end
        @(posedge aclk);
        chk(pri_req_n, 1'h0);
        up_pending <= '0;
        up_done    <= '1;
        @(posedge aclk);
        up_done <= '0;
        // let the stale grant and its short park run out
        repeat (6) @(posedge aclk);
        chk(pri_req_n, 1'h1);
        chk(pri_start, 1'h0);
    endtask : t_pri
    task t_park;
        park <= '1;
        n = 0;
        while (pri_ad_cbe_oe !== 1'h1 && n < 10) step;
        chk(n < 10, 1'h1);
        chk(upstream_parity_oe, 1'h0);
        @(posedge aclk);
        chk(upstream_parity_oe, 1'h1);
        park <= '0;
        repeat (6) @(posedge aclk);
        chk({pri_ad_cbe_oe, upstream_parity_oe}, 2'h0);
    endtask : t_park
    task t_sec;
        chk(sec_bridge_gnt, 1'h1);
        want <= 4'h2;
        n = 0;
        while (sec_bridge_gnt !== 1'h0 && n < 20) step;
        chk(n < 20, 1'h1);
        chk(sec_gnt_n, 4'hf);
        @(posedge aclk);
        chk(sec_gnt_n, 4'hd);
        n = 0;
        while (sec_gnt_n[1] === 1'h0 && n < 40) step;
        chk(n, 16);
        want <= '0;
        axw(12'h048, 32'h2, 2'h0);
        repeat (4) @(posedge aclk);
        chk({sec_bridge_gnt, sec_gnt_n}, 5'h1f);
        axw(12'h048, 32'h1, 2'h0);
        repeat (2) @(posedge aclk);
        chk(sec_gnt_oe, 1'h0);
        axw(12'h048, 32'h0, 2'h0);
    endtask : t_sec
    task t_pre;
        sec_frame_n    <= '0;
        sec_bridge_req <= '1;
        repeat (4) @(posedge aclk);
        chk({sec_gnt_oe, sec_bridge_gnt}, 2'h3);
        want <= 4'h1;
        n = 0;
        while (sec_bridge_gnt === 1'h1 && n < 20) step;
        chk(sec_bridge_gnt, 1'h0);
        chk(sec_gnt_n, 4'he);
        want           <= '0;
        sec_bridge_req <= '0;
        sec_frame_n    <= '1;
        repeat (4) @(posedge aclk);
    endtask : t_pre

    // ----------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= '1;
        @(posedge aclk);
        t_regs;
        t_pri;
        t_park;
        t_sec;
        t_pre;
        results;
    end
    initial
    begin
        #400000;
        errors++;
        results;
    end
endmodule : test_pci_bridge_bus_arbitration
